// ===== pkg/pie_pkg.sv
// Purpose: Constants and types of the packed-integer fault and alias unit
// Assumes: Avalon-MM slave, byte addresses, 32-bit data, one clock
// Notes: Packed registers share storage with the legacy data stack
// Summary of operation
// - Packed ops never raise legacy FP exceptions
// - Packed ops keep flags and FP status bits other than the stack top
// - Emulation flag set: packed op gives invalid-opcode
// - Task-switched flag set: packed op gives device-unavailable
// - Pending FP exception faults before packed op
// - Handler sees legacy FP state untouched
// - Handler return runs the deferred packed op
// - Memory faults pass; alignment only when enabled
// - Tag fields belong to physical slots
// - Packed register n is physical slot n
// - Logical n is slot top plus n, mod eight
// - Top two: logical 0 is slot two
// - Extended save also stores wide and SIMD control
// - Extended restore also reloads wide and SIMD control
// - Saves store every slot, tags ignored
// - Debug stepping same for all instructions
// - Packed write sets exponent bits to ones
// - Packed ops except empty mark tags valid
// - Empty-state op marks all tags empty
// - Packed ops reset stack top to zero
package pie_pkg;
  localparam int NUM_SLOTS = 8;
  localparam int SLOT_W = 80;
  localparam int TOS_W = 3;
  localparam logic [15:0] EXP_ONES = 16'hffff;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_DATA_LO = 8'h08;
  localparam logic [7:0] OFF_DATA_HI = 8'h0c;
  localparam logic [7:0] OFF_DATA_EXP = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_FP_STATUS = 8'h18;
  localparam logic [7:0] OFF_FLAGS = 8'h1c;
  localparam logic [7:0] OFF_SIMD_CSR = 8'h20;
  // Control register bits
  localparam int CTRL_EMUL_BIT = 0;
  localparam int CTRL_TS_BIT = 1;
  localparam int CTRL_ALIGN_BIT = 2;
  localparam int CTRL_STEP_BIT = 3;
  // Command register fields
  localparam int CMD_IDX_LSB = 4;
  localparam int CMD_MEMF_LSB = 8;
  localparam int CMD_MISAL_BIT = 10;
  localparam int CMD_FPEXC_BIT = 11;
  // Status register fields
  localparam int STAT_TOS_LSB = 16;
  localparam int STAT_FAULT_LSB = 20;
  localparam int STAT_DEFER_BIT = 24;
  localparam int STAT_PEND_BIT = 25;
  localparam int STAT_LOGPOS_LSB = 28;
  // Legacy status word: stack top field and error summary
  localparam int FSW_TOS_LSB = 11;
  localparam int FSW_ES_BIT = 7;
  // Values after reset, and the all-valid tag word
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CSR_RST = 32'h0000_0000;
  localparam logic [15:0] FSW_RST = 16'h0000;
  localparam logic [15:0] TAG_ALL_EMPTY = 16'hffff;
  localparam logic [15:0] TAG_ALL_VALID = 16'h0000;
  // Command opcodes
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_PK_READ = 4'h1;
  localparam logic [3:0] OP_PK_WRITE = 4'h2;
  localparam logic [3:0] OP_EMPTY = 4'h3;
  localparam logic [3:0] OP_ST_READ = 4'h4;
  localparam logic [3:0] OP_ST_WRITE = 4'h5;
  localparam logic [3:0] OP_FX_SAVE = 4'h6;
  localparam logic [3:0] OP_FX_RESTORE = 4'h7;
  localparam logic [3:0] OP_LEG_SAVE = 4'h8;
  localparam logic [3:0] OP_LEG_RESTORE = 4'h9;
  localparam logic [3:0] OP_WIDE_WRITE = 4'ha;
  localparam logic [3:0] OP_HANDLER_RET = 4'hb;
  // Memory fault requests from the address unit
  localparam logic [1:0] MEMF_NONE = 2'h0;
  localparam logic [1:0] MEMF_SS = 2'h1;
  localparam logic [1:0] MEMF_GP = 2'h2;
  localparam logic [1:0] MEMF_PF = 2'h3;
  // Fault codes
  localparam logic [3:0] FLT_NONE = 4'h0;
  localparam logic [3:0] FLT_UD = 4'h1;
  localparam logic [3:0] FLT_NM = 4'h2;
  localparam logic [3:0] FLT_MF = 4'h3;
  localparam logic [3:0] FLT_SS = 4'h4;
  localparam logic [3:0] FLT_GP = 4'h5;
  localparam logic [3:0] FLT_PF = 4'h6;
  localparam logic [3:0] FLT_AC = 4'h7;
  localparam logic [3:0] FLT_DBG = 4'h8;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SAVE, ST_LOAD} pie_state_t;

  function automatic logic [31:0] pie_be_merge(input logic [31:0] old,
      input logic [31:0] wr, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wr[8*i +: 8];
    end
    return r;
  endfunction : pie_be_merge
endpackage : pie_pkg

// ===== design/pie_stack_map.sv
// Purpose: Map between logical stack positions and physical slots
// Assumes: Eight slots, so the sums wrap naturally in three bits
// Notes: Purely combinational
`timescale 1ns/1ns
module pie_stack_map import pie_pkg::*; (
  input wire logic [TOS_W-1:0] top,
  input wire logic [TOS_W-1:0] logIdx,
  input wire logic [TOS_W-1:0] physIdx,
  output logic [TOS_W-1:0] physOfLog,
  output logic [TOS_W-1:0] logOfPhys
);
  assign physOfLog = TOS_W'(top + logIdx);
  assign logOfPhys = TOS_W'(physIdx - top);
endmodule : pie_stack_map

// ===== design/pie_save_seq.sv
// Purpose: Walk every data slot once for a save or restore
// Assumes: start is a one-cycle pulse while idle
// Notes: Never skips a slot, whatever the tags say
`timescale 1ns/1ns
module pie_save_seq import pie_pkg::*; #(
  parameter int SLOTS = NUM_SLOTS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic start,
  output logic [$clog2(SLOTS)-1:0] slot,
  output logic active,
  output logic last
);
  typedef struct packed {
    logic busy;
    logic [$clog2(SLOTS)-1:0] cnt;
  } pie_seq_t;
  pie_seq_t q, d;

  always_comb begin
    d = q;
    if (start) begin
      d.busy = 1'b1;
      d.cnt = '0;
    end else if (q.busy) begin
      d.cnt = q.cnt + 1'b1;
      if (last) d.busy = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) q <= '0;
    else q <= d;
  end

  assign slot = q.cnt;
  assign active = q.busy;
  assign last = q.busy && (q.cnt == ($clog2(SLOTS))'(SLOTS - 1));
endmodule : pie_save_seq

// ===== design/pie_core.sv
// Purpose: Fault checks, shared state and aliasing for packed-integer ops
// Assumes: Core decodes an instruction by writing the command register
// Notes: Command write holds waitrequest until the operation is done
`timescale 1ns/1ns
module pie_core import pie_pkg::*; #(
  parameter int WIDE_W = 128
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic faultRaise,
  output logic [3:0] faultCode
);
  typedef struct packed {
    pie_state_t state;
    logic ack;
    logic faultPulse;
    logic [3:0] fault;
    logic fpPend;
    logic deferred;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] cmd;
    logic [31:0] defCmd;
    logic [31:0] defLo;
    logic [31:0] defHi;
    logic [31:0] dataLo;
    logic [31:0] dataHi;
    logic [15:0] dataExp;
    logic [31:0] flags;
    logic [31:0] simdCsr;
    logic [31:0] saveCsr;
    logic [15:0] tagWord;
    logic [15:0] fpStatus;
    logic [15:0] saveTag;
    logic [15:0] saveFsw;
    logic [NUM_SLOTS-1:0][SLOT_W-1:0] phys;
    logic [NUM_SLOTS-1:0][SLOT_W-1:0] savePhys;
    logic [NUM_SLOTS-1:0][WIDE_W-1:0] wide;
    logic [NUM_SLOTS-1:0][WIDE_W-1:0] saveWide;
  } pie_core_t;

  pie_core_t q, d;
  logic busReq;
  logic [3:0] op;
  logic [3:0] wrOp;
  logic [TOS_W-1:0] cmdIdx;
  logic [TOS_W-1:0] top;
  logic [TOS_W-1:0] stSlot;
  logic [TOS_W-1:0] logPos;
  logic isPacked;
  logic fxOp;
  logic [3:0] pkFault;
  logic pkExec;
  logic seqStart;
  logic [TOS_W-1:0] seqSlot;
  logic seqActive;
  logic seqLast;

  // ----------------------------------------------------------------
  // Decode and fault priority
  // ----------------------------------------------------------------
  assign busReq = (avs_read || avs_write) && !q.ack;
  assign op = q.cmd[3:0];
  assign wrOp = avs_writedata[3:0];
  assign cmdIdx = q.cmd[CMD_IDX_LSB +: TOS_W];
  assign top = q.fpStatus[FSW_TOS_LSB +: TOS_W];
  assign isPacked = (op == OP_PK_READ) || (op == OP_PK_WRITE) || (op == OP_EMPTY);
  assign fxOp = (op == OP_FX_SAVE) || (op == OP_FX_RESTORE);

  // Emulation outranks task switch, which outranks a pending FP error
  always_comb begin
    pkFault = FLT_NONE;
    if (q.ctrl[CTRL_EMUL_BIT]) pkFault = FLT_UD;
    else if (q.ctrl[CTRL_TS_BIT]) pkFault = FLT_NM;
    else if (q.fpPend) pkFault = FLT_MF;
    else if (q.cmd[CMD_MEMF_LSB +: 2] == MEMF_SS) pkFault = FLT_SS;
    else if (q.cmd[CMD_MEMF_LSB +: 2] == MEMF_GP) pkFault = FLT_GP;
    else if (q.cmd[CMD_MEMF_LSB +: 2] == MEMF_PF) pkFault = FLT_PF;
    else if (q.cmd[CMD_MISAL_BIT] && q.ctrl[CTRL_ALIGN_BIT]) pkFault = FLT_AC;
  end
  assign pkExec = (q.state == ST_EXEC) && isPacked && (pkFault == FLT_NONE);

  pie_stack_map u_map (
    .top(top),
    .logIdx(cmdIdx),
    .physIdx(cmdIdx),
    .physOfLog(stSlot),
    .logOfPhys(logPos)
  );

  assign seqStart = (q.state == ST_IDLE) && (d.state == ST_SAVE || d.state == ST_LOAD);

  pie_save_seq #(.SLOTS(NUM_SLOTS)) u_seq (
    .core_clk(core_clk),
    .srst(srst),
    .start(seqStart),
    .slot(seqSlot),
    .active(seqActive),
    .last(seqLast)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] fltNow;
    logic done;
    fltNow = FLT_NONE;
    done = 1'b0;
    d = q;
    d.ack = 1'b0;
    d.faultPulse = 1'b0;
    unique case (q.state)
      ST_IDLE: begin
        if (busReq && avs_read) begin
          d.ack = 1'b1;
          case (avs_address)
            OFF_CTRL: d.rdata = q.ctrl;
            OFF_CMD: d.rdata = q.cmd;
            OFF_DATA_LO: d.rdata = q.dataLo;
            OFF_DATA_HI: d.rdata = q.dataHi;
            OFF_DATA_EXP: d.rdata = {16'h0000, q.dataExp};
            OFF_STATUS: d.rdata = {1'b0, logPos, 2'h0, q.fpPend, q.deferred, q.fault,
                                   1'b0, top, q.tagWord};
            OFF_FP_STATUS: d.rdata = {16'h0000, q.fpStatus};
            OFF_FLAGS: d.rdata = q.flags;
            OFF_SIMD_CSR: d.rdata = q.simdCsr;
            default: d.rdata = 32'h0000_0000;
          endcase
        end else if (busReq && avs_write) begin
          d.ack = 1'b1;
          case (avs_address)
            OFF_CTRL: d.ctrl = pie_be_merge(q.ctrl, avs_writedata, avs_byteenable);
            OFF_DATA_LO: d.dataLo = pie_be_merge(q.dataLo, avs_writedata, avs_byteenable);
            OFF_DATA_HI: d.dataHi = pie_be_merge(q.dataHi, avs_writedata, avs_byteenable);
            OFF_DATA_EXP: d.dataExp = 16'(pie_be_merge({16'h0000, q.dataExp}, avs_writedata,
                                                      avs_byteenable));
            OFF_FP_STATUS: d.fpStatus = 16'(pie_be_merge({16'h0000, q.fpStatus},
                                                        avs_writedata, avs_byteenable));
            OFF_FLAGS: d.flags = pie_be_merge(q.flags, avs_writedata, avs_byteenable);
            OFF_SIMD_CSR: d.simdCsr = pie_be_merge(q.simdCsr, avs_writedata, avs_byteenable);
            OFF_CMD: begin
              // The whole word is taken: a command is never partly written
              d.cmd = avs_writedata;
              d.ack = 1'b0;
              if (wrOp == OP_FX_SAVE || wrOp == OP_LEG_SAVE) d.state = ST_SAVE;
              else if (wrOp == OP_FX_RESTORE || wrOp == OP_LEG_RESTORE) d.state = ST_LOAD;
              else d.state = ST_EXEC;
            end
            default: ;
          endcase
        end
      end
      ST_EXEC: begin
        done = 1'b1;
        if (isPacked) begin
          fltNow = pkFault;
          if (pkFault == FLT_MF) begin
            // Park the op; legacy state stays as the handler must see it
            d.deferred = 1'b1;
            d.defCmd = q.cmd;
            d.defLo = q.dataLo;
            d.defHi = q.dataHi;
          end else if (pkFault == FLT_NONE) begin
            d.tagWord = (op == OP_EMPTY) ? TAG_ALL_EMPTY : TAG_ALL_VALID;
            d.fpStatus[FSW_TOS_LSB +: TOS_W] = '0;
            if (op == OP_PK_WRITE) d.phys[cmdIdx] = {EXP_ONES, q.dataHi, q.dataLo};
            if (op == OP_PK_READ) begin
              d.dataLo = q.phys[cmdIdx][31:0];
              d.dataHi = q.phys[cmdIdx][63:32];
            end
          end
        end else begin
          unique case (op)
            OP_ST_READ: {d.dataExp, d.dataHi, d.dataLo} = q.phys[stSlot];
            OP_ST_WRITE: begin
              d.phys[stSlot] = {q.dataExp, q.dataHi, q.dataLo};
              d.tagWord[2*stSlot +: 2] = 2'h0;
              if (q.cmd[CMD_FPEXC_BIT]) begin
                d.fpPend = 1'b1;
                d.fpStatus[FSW_ES_BIT] = 1'b1;
              end
            end
            OP_WIDE_WRITE: d.wide[cmdIdx] = {(WIDE_W / 64){q.dataHi, q.dataLo}};
            OP_HANDLER_RET: begin
              d.fpPend = 1'b0;
              d.fpStatus[FSW_ES_BIT] = 1'b0;
              if (q.deferred) begin
                // Re-run the parked op before answering the bus
                d.deferred = 1'b0;
                d.cmd = q.defCmd;
                d.dataLo = q.defLo;
                d.dataHi = q.defHi;
                d.state = ST_EXEC;
                done = 1'b0;
              end
            end
            OP_NOP: ;
            default: fltNow = FLT_UD;
          endcase
        end
      end
      ST_SAVE: begin
        if (seqActive) begin
          d.savePhys[seqSlot] = q.phys[seqSlot];
          if (fxOp) d.saveWide[seqSlot] = q.wide[seqSlot];
        end
        if (seqLast) begin
          d.saveTag = q.tagWord;
          d.saveFsw = q.fpStatus;
          if (fxOp) d.saveCsr = q.simdCsr;
          d.tagWord = TAG_ALL_EMPTY;
          done = 1'b1;
        end
      end
      ST_LOAD: begin
        if (seqActive) begin
          d.phys[seqSlot] = q.savePhys[seqSlot];
          if (fxOp) d.wide[seqSlot] = q.saveWide[seqSlot];
        end
        if (seqLast) begin
          d.tagWord = q.saveTag;
          d.fpStatus = q.saveFsw;
          if (fxOp) d.simdCsr = q.saveCsr;
          done = 1'b1;
        end
      end
    endcase
    if (done) begin
      // Trap after any completed op, packed or not
      if (fltNow == FLT_NONE && q.ctrl[CTRL_STEP_BIT]) fltNow = FLT_DBG;
      d.state = ST_IDLE;
      d.ack = 1'b1;
      d.fault = fltNow;
      d.faultPulse = (fltNow != FLT_NONE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.simdCsr <= CSR_RST;
      q.fpStatus <= FSW_RST;
      q.tagWord <= TAG_ALL_EMPTY;
    end else begin
      q <= d;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !q.ack;
  assign avs_readdata = q.rdata;
  assign faultRaise = q.faultPulse;
  assign faultCode = q.fault;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_pk_try;
    (q.state == ST_EXEC) && isPacked;
  endsequence
  sequence s_ret_deferred;
    (q.state == ST_EXEC) && (op == OP_HANDLER_RET) && q.deferred;
  endsequence

  a_pk_no_fpexc: assert property (s_pk_try |=> !$rose(q.fpPend))
    else $error("packed op raised a legacy FP exception");
  a_pk_flags_kept: assert property (pkExec |=> $stable(q.flags) &&
      q.fpStatus[10:0] == $past(q.fpStatus[10:0]))
    else $error("packed op changed flags or status bits");
  a_emul_ud: assert property (s_pk_try ##0 q.ctrl[CTRL_EMUL_BIT] |=>
      q.fault == FLT_UD && faultRaise && $stable(q.phys))
    else $error("emulation flag did not give invalid opcode");
  a_ts_nm: assert property (s_pk_try ##0 (q.ctrl[1:0] == 2'h2) |=> q.fault == FLT_NM)
    else $error("task switched flag did not give device unavailable");
  a_mf_defer: assert property (s_pk_try ##0 (q.ctrl[1:0] == 2'h0) && q.fpPend |=>
      q.fault == FLT_MF && q.deferred && $stable(q.tagWord) && $stable(q.phys))
    else $error("pending FP error not raised before packed op");
  a_mf_state_kept: assert property (q.deferred && q.state == ST_IDLE && !avs_write |=>
      $stable(q.phys) && $stable(q.tagWord) && $stable(q.fpStatus))
    else $error("legacy state changed while handler runs");
  a_ret_reexec: assert property (s_ret_deferred |=> q.state == ST_EXEC &&
      q.cmd == $past(q.defCmd) ##1 q.state == ST_IDLE)
    else $error("deferred packed op not re-run on return");
  a_ac_gated: assert property (s_pk_try ##0 !q.ctrl[CTRL_ALIGN_BIT] |=>
      q.fault != FLT_AC)
    else $error("alignment fault while checking disabled");
  a_tag_phys: assert property ((q.state == ST_EXEC) && op == OP_ST_WRITE |=>
      q.tagWord[2*$past(stSlot) +: 2] == 2'h0)
    else $error("tag not tied to physical slot");
  a_pk_direct: assert property (pkExec && op == OP_PK_WRITE |=>
      q.phys[$past(cmdIdx)] == {EXP_ONES, $past(q.dataHi), $past(q.dataLo)})
    else $error("packed write slot or exponent wrong");
  a_map_wrap: assert property (stSlot == TOS_W'(top + cmdIdx) &&
      TOS_W'(logPos + top) == cmdIdx)
    else $error("logical to physical map broken");
  a_map_top2: assert property (top == 3'h2 && cmdIdx == 3'h0 |->
      stSlot == 3'h2 && logPos == 3'h6)
    else $error("top two mapping wrong");
  a_save_all: assert property (seqLast && q.state == ST_SAVE |=>
      q.savePhys == $past(q.phys) && (!$past(fxOp) || q.saveWide == $past(q.wide)))
    else $error("save skipped a slot or wide register");
  a_restore_wide: assert property (seqLast && q.state == ST_LOAD && fxOp |=>
      q.wide == $past(q.saveWide) && q.simdCsr == $past(q.saveCsr))
    else $error("restore missed wide or SIMD control state");
  a_step_trap: assert property (q.ack && $past(q.state) != ST_IDLE &&
      q.ctrl[CTRL_STEP_BIT] |-> q.fault != FLT_NONE)
    else $error("single step trap missing");
  a_pk_tags: assert property (pkExec |=> q.tagWord ==
      ($past(op) == OP_EMPTY ? TAG_ALL_EMPTY : TAG_ALL_VALID) && top == 3'h0)
    else $error("packed op tag or top update wrong");
endmodule : pie_core

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the packed-integer fault and alias unit
// Assumes: Avalon-MM slave at 20 MHz, synchronous active-high reset
// Notes: Expected values follow the register map and fault priority
`timescale 1ns/1ns
module tb import pie_pkg::*; ;
  logic core_clk;
  logic srst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic faultRaise;
  logic [3:0] faultCode;
  int errors;
  int n_checks;
  int cycles;
  logic [31:0] rdq;
  logic frq;
  logic [3:0] fcq;

  pie_core dut_u (
    .core_clk(core_clk),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .faultRaise(faultRaise),
    .faultCode(faultCode)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low; one idle cycle after
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdq = avs_readdata;
    frq = faultRaise;
    fcq = faultCode;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic rd(input logic [7:0] a, input string what, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    chk(what, rdq, want);
  endtask : rd

  task automatic op(input logic [3:0] o, input logic [2:0] idx, input logic [3:0] ex,
      input logic [3:0] want);
    bus(1'b1, OFF_CMD, {20'h0, ex, 1'b0, idx, o});
    chk("fault code", {28'h0, fcq}, {28'h0, want});
    chk("fault pulse", {31'h0, frq}, {31'h0, want != FLT_NONE});
  endtask : op

  task automatic pkw(input logic [2:0] idx, input logic [31:0] lo);
    bus(1'b1, OFF_DATA_LO, lo);
    bus(1'b1, OFF_DATA_EXP, 32'h0);
    op(OP_PK_WRITE, idx, 4'h0, FLT_NONE);
  endtask : pkw

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Whole sequence needs under 3000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors++;
      $display("ERROR timeout expected done seen hang");
      summarize();
    end
  end

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    srst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(OFF_STATUS, "status after reset", 32'h0000_ffff);
    rd(8'hfc, "unmapped read", 32'h0);
    bus(1'b1, OFF_STATUS, 32'h0);
    rd(OFF_STATUS, "status read-only", 32'h0000_ffff);
    op(OP_NOP, 3'h0, 4'h0, FLT_NONE);
    op(4'hf, 3'h0, 4'h0, FLT_UD);
    bus(1'b1, OFF_DATA_HI, 32'h5a5a_0000);
    for (int i = 0; i < 8; i++) pkw(3'(i), 32'h0a0b_0c00 | i);
    op(OP_ST_READ, 3'h3, 4'h0, FLT_NONE);
    rd(OFF_DATA_EXP, "exponent ones", 32'h0000_ffff);
    rd(OFF_DATA_LO, "slot three", 32'h0a0b_0c03);
    rd(OFF_STATUS, "tags valid top zero", 32'h3000_0000);
    bus(1'b1, OFF_FP_STATUS, 32'h0000_1045);
    for (int n = 0; n < 8; n++) begin
      op(OP_ST_READ, 3'(n), 4'h0, FLT_NONE);
      rd(OFF_DATA_LO, "logical map", 32'h0a0b_0c00 | ((n + 2) % 8));
    end
    bus(1'b1, OFF_FLAGS, 32'h0000_08d5);
    op(OP_PK_READ, 3'h1, 4'h0, FLT_NONE);
    rd(OFF_DATA_LO, "packed read", 32'h0a0b_0c01);
    rd(OFF_FLAGS, "flags kept", 32'h0000_08d5);
    rd(OFF_FP_STATUS, "status word", 32'h0000_0045);
    op(OP_EMPTY, 3'h0, 4'h0, FLT_NONE);
    rd(OFF_STATUS, "tags empty", 32'h0000_ffff);
    // Emulation wins over task switched
    bus(1'b1, OFF_CTRL, 32'h1);
    op(OP_PK_READ, 3'h0, 4'h0, FLT_UD);
    bus(1'b1, OFF_CTRL, 32'h2);
    op(OP_PK_READ, 3'h0, 4'h0, FLT_NM);
    bus(1'b1, OFF_CTRL, 32'h3);
    op(OP_PK_WRITE, 3'h0, 4'h0, FLT_UD);
    bus(1'b1, OFF_CTRL, 32'h0);
    for (int m = 1; m < 4; m++) op(OP_PK_READ, 3'h0, 4'(m), 4'(3 + m));
    op(OP_PK_READ, 3'h0, 4'h4, FLT_NONE);
    bus(1'b1, OFF_CTRL, 32'h4);
    op(OP_PK_READ, 3'h0, 4'h4, FLT_AC);
    bus(1'b1, OFF_CTRL, 32'h0);
    // Deferred op behind a pending legacy exception, stack top at two
    op(OP_EMPTY, 3'h0, 4'h0, FLT_NONE);
    bus(1'b1, OFF_FP_STATUS, 32'h0000_1045);
    bus(1'b1, OFF_CMD, {20'h0, 4'h8, 1'b0, 3'h0, OP_ST_WRITE});
    rd(OFF_STATUS, "tag of slot two", 32'h6202_ffcf);
    rd(OFF_FP_STATUS, "error summary set", 32'h0000_10c5);
    bus(1'b1, OFF_DATA_LO, 32'hcafe_0005);
    op(OP_PK_WRITE, 3'h5, 4'h0, FLT_MF);
    rd(OFF_STATUS, "parked and pending", 32'h3332_ffcf);
    rd(OFF_FP_STATUS, "state during handler", 32'h0000_10c5);
    bus(1'b1, OFF_DATA_LO, 32'h0);
    op(OP_HANDLER_RET, 3'h0, 4'h0, FLT_NONE);
    op(OP_PK_READ, 3'h5, 4'h0, FLT_NONE);
    rd(OFF_DATA_LO, "deferred write", 32'hcafe_0005);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("pending cleared", {30'h0, rdq[25:24]}, 32'h0);
    // Save and restore with every tag empty
    bus(1'b1, OFF_SIMD_CSR, 32'h0000_1f80);
    op(OP_WIDE_WRITE, 3'h0, 4'h0, FLT_NONE);
    pkw(3'h7, 32'h7777_0007);
    op(OP_EMPTY, 3'h0, 4'h0, FLT_NONE);
    op(OP_FX_SAVE, 3'h0, 4'h0, FLT_NONE);
    bus(1'b1, OFF_SIMD_CSR, 32'h0);
    pkw(3'h7, 32'h0);
    op(OP_FX_RESTORE, 3'h0, 4'h0, FLT_NONE);
    rd(OFF_SIMD_CSR, "control restored", 32'h0000_1f80);
    op(OP_PK_READ, 3'h7, 4'h0, FLT_NONE);
    rd(OFF_DATA_LO, "slot restored", 32'h7777_0007);
    op(OP_EMPTY, 3'h0, 4'h0, FLT_NONE);
    op(OP_LEG_SAVE, 3'h0, 4'h0, FLT_NONE);
    pkw(3'h7, 32'h0);
    op(OP_LEG_RESTORE, 3'h0, 4'h0, FLT_NONE);
    op(OP_PK_READ, 3'h7, 4'h0, FLT_NONE);
    rd(OFF_DATA_LO, "legacy restored", 32'h7777_0007);
    // Step trap for packed and legacy ops alike
    bus(1'b1, OFF_CTRL, 32'h8);
    op(OP_PK_READ, 3'h0, 4'h0, FLT_DBG);
    op(OP_ST_READ, 3'h0, 4'h0, FLT_DBG);
    bus(1'b1, OFF_CTRL, 32'h0);
    summarize();
  end
endmodule : tb
